//--- inc/dms_pkg.sv
// package of constants for the multimeter setup and status block
// assumes a single 100 MHz clock domain and synchronous reset
package dms_pkg;
    // ==========================================================
    // logical address
    localparam logic [7:0]  ADDR_FACTORY  = 8'h18; // factory switch value 24
    localparam logic [7:0]  ADDR_STAT_MIN = 8'h01; // lowest static address
    localparam logic [7:0]  ADDR_STAT_MAX = 8'hFE; // highest static address
    localparam logic [7:0]  ADDR_DYNAMIC  = 8'hFF; // dynamic assignment request
    localparam logic [7:0]  ADDR_NONE     = 8'h00; // no valid address yet
    // ==========================================================
    // line frequency codes, in hertz
    localparam logic [8:0]  LF_50         = 9'h032; // 50 Hz
    localparam logic [8:0]  LF_60         = 9'h03C; // 60 Hz
    localparam logic [8:0]  LF_400        = 9'h190; // 400 Hz
    // ==========================================================
    // error codes
    localparam logic [15:0] ERR_NONE      = 16'h0000; // answer when the queue is empty
    // ==========================================================
    // synchroniser depth
    localparam int          SYNC_STAGES   = 3;
    // ==========================================================
    // power-on states
    typedef enum logic [2:0] {
        DMS_ST_TEST = 3'b001, // self-test running, failure lamp lit
        DMS_ST_OK   = 3'b010, // internal link up
        DMS_ST_FAIL = 3'b100  // internal link never came up
    } dms_post_t;
endpackage : dms_pkg

//--- core/dms_err_fifo.sv
// first-in first-out error queue with clear
// assumes push and pop from the same clock domain
module dms_err_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8
) (
    input  wire logic             clk_i,
    input  wire logic             reset_i,
    input  wire logic             push_i,  // enqueue one code
    input  wire logic [WIDTH-1:0] data_i,  // code to enqueue
    input  wire logic             pop_i,   // dequeue the head
    input  wire logic             clear_i, // drop all entries
    output logic      [WIDTH-1:0] head_o,  // oldest entry
    output logic                  empty_o, // nothing queued
    output logic                  full_o   // no room left
);
    localparam int AW = $clog2(DEPTH);
    // ==========================================================
    // storage and pointers
    logic [WIDTH-1:0] mem_q [DEPTH];       // entry array
    logic [AW-1:0]    wr_q;                // write pointer
    logic [AW-1:0]    rd_q;                // read pointer
    logic [AW:0]      cnt_q;               // occupancy
    wire              do_pop  = pop_i && !empty_o;
    wire              do_push = push_i && (!full_o || do_pop || clear_i);

    function automatic logic [AW-1:0] inc(input logic [AW-1:0] p);
        inc = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
    endfunction : inc

    assign empty_o = (cnt_q == '0);
    assign full_o  = (cnt_q == (AW+1)'(DEPTH));
    assign head_o  = mem_q[rd_q];

    // ==========================================================
    // pointer and count update; a push in a clear cycle is kept
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end else if (clear_i) begin
            if (do_push) wr_q <= inc(wr_q);
            rd_q  <= wr_q;                 // drop all older entries
            cnt_q <= (AW+1)'(do_push);     // only the new entry survives
        end else begin
            if (do_push) wr_q <= inc(wr_q);
            if (do_pop)  rd_q <= inc(rd_q);
            cnt_q <= cnt_q + (AW+1)'(do_push) - (AW+1)'(do_pop);
        end
    end

    // ==========================================================
    // data write
    always_ff @(posedge clk_i) begin
        if (do_push) mem_q[wr_q] <= data_i;
    end
endmodule : dms_err_fifo

//--- core/dms_setup_status.sv
// setup and status logic of a message-based bus multimeter module
// assumes a command decoder drives the one-cycle command strobes
// What this block does
// - address switch ships set to 24
// - 1..254 static, 255 requests dynamic address
// - interrupter role, no local priority setting
// - accept 50, 60 or 400 Hz reference
// - reference is 60 Hz after power-on
// - 400 Hz setting stores 50 Hz
// - query reports stored reference, 50 or 60
// - failed lamp lit during self-test until link
// - access lamp lit only while manager talks
// - error lamp lit while queue non-empty
// - queue bad commands, self-test, calibration failures, one per cycle, self-test first
// - error query pops one, empty gives +0
// - clear-status empties queue silently but keeps an error arriving in its cycle
// - sample lamp lit while input is sampled
module dms_setup_status #(
    parameter int ERR_W      = 16,
    parameter int ERR_DEPTH  = 8,
    parameter int POST_LIMIT = 100000 // cycles allowed for internal link
) (
    input  wire logic             clk_i,
    input  wire logic             reset_i,
    input  wire logic [7:0]       addr_switch_i,       // switch pins
    input  wire logic             dyn_assign_i,        // manager assigns address
    input  wire logic [7:0]       dyn_addr_i,          // assigned address
    input  wire logic             lf_set_i,            // line frequency set command
    input  wire logic [8:0]       lf_value_i,          // requested hertz
    input  wire logic             lf_query_i,          // line frequency query
    input  wire logic             int_link_ok_i,       // internal link up (pin)
    input  wire logic             mgr_busy_i,          // manager transfer active
    input  wire logic             sampling_i,          // converter sampling
    input  wire logic             cmd_err_i,           // command executed badly
    input  wire logic [ERR_W-1:0] cmd_err_code_i,      // its code
    input  wire logic             cal_err_i,           // calibration failed
    input  wire logic [ERR_W-1:0] cal_err_code_i,      // its code
    input  wire logic [ERR_W-1:0] test_err_code_i,     // code for self-test failure
    input  wire logic             err_query_i,         // error query command
    input  wire logic             clear_status_i,      // clear-status command
    input  wire logic             irq_req_i,           // block wants an interrupt
    output logic      [7:0]       log_addr_o,          // active logical address
    output logic                  addr_dynamic_o,      // waiting for assignment
    output logic                  lf_is_50_o,          // stored reference is 50 Hz
    output logic                  lf_resp_valid_o,     // query answer strobe
    output logic      [8:0]       lf_resp_o,           // answer: 50 or 60
    output logic                  lf_bad_value_o,      // rejected set value
    output logic                  err_resp_valid_o,    // error query answer strobe
    output logic      [ERR_W-1:0] err_resp_o,          // popped code or +0
    output logic                  led_failed_o,
    output logic                  led_access_o,
    output logic                  led_errors_o,
    output logic                  led_sample_o,
    output logic                  irq_o                // interrupter request line
);
    // ==========================================================
    // pin synchronisers
    localparam int          LAST = dms_pkg::SYNC_STAGES - 1; // index of the third stage
    logic [LAST:0]          link_s_q;    // internal link sync chain
    logic [LAST:0]          samp_s_q;    // sampling sync chain
    logic                   link_q;      // filtered link level
    logic                   samp_q;      // filtered sampling level

    // shift chains; value taken when last two stages agree
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            link_s_q <= '0;
            samp_s_q <= '0;
            link_q   <= 1'b0;
            samp_q   <= 1'b0;
        end else begin
            link_s_q <= {link_s_q[LAST-1:0], int_link_ok_i};
            samp_s_q <= {samp_s_q[LAST-1:0], sampling_i};
            if (link_s_q[LAST-1] == link_s_q[LAST]) link_q <= link_s_q[LAST];
            if (samp_s_q[LAST-1] == samp_s_q[LAST]) samp_q <= samp_s_q[LAST];
        end
    end

    // ==========================================================
    // logical address
    logic [7:0] dyn_q;                   // address given by manager
    logic       dyn_got_q;               // assignment received
    wire        sw_static  = (addr_switch_i >= dms_pkg::ADDR_STAT_MIN) &&
                             (addr_switch_i <= dms_pkg::ADDR_STAT_MAX);
    wire        sw_dynamic = (addr_switch_i == dms_pkg::ADDR_DYNAMIC);
    wire        dyn_ok     = (dyn_addr_i >= dms_pkg::ADDR_STAT_MIN) &&
                             (dyn_addr_i <= dms_pkg::ADDR_STAT_MAX);

    // take assigned address only in dynamic mode
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            dyn_q     <= dms_pkg::ADDR_NONE;
            dyn_got_q <= 1'b0;
        end else if (!sw_dynamic) begin
            dyn_got_q <= 1'b0;
        end else if (dyn_assign_i && dyn_ok) begin
            dyn_q     <= dyn_addr_i;
            dyn_got_q <= 1'b1;
        end
    end

    // registered address output; factory value 24 lives on the switch
    logic [7:0] addr_q;
    logic       adyn_q;
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            addr_q <= dms_pkg::ADDR_NONE;
            adyn_q <= 1'b0;
        end else begin
            addr_q <= sw_static ? addr_switch_i :
                      (sw_dynamic && dyn_got_q) ? dyn_q : dms_pkg::ADDR_NONE;
            adyn_q <= sw_dynamic && !dyn_got_q;
        end
    end
    assign log_addr_o     = addr_q;
    assign addr_dynamic_o = adyn_q;

    // ==========================================================
    // line frequency reference
    logic lf50_q;                        // 1: 50 Hz, 0: 60 Hz
    wire  lf_want_50 = (lf_value_i == dms_pkg::LF_50) ||
                       (lf_value_i == dms_pkg::LF_400);
    wire  lf_legal   = lf_want_50 || (lf_value_i == dms_pkg::LF_60);
    logic lf_bad_q;
    logic lf_rv_q;
    logic [8:0] lf_r_q;

    // store, reject and answer
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            lf50_q   <= 1'b0;
            lf_bad_q <= 1'b0;
            lf_rv_q  <= 1'b0;
            lf_r_q   <= dms_pkg::LF_60;
        end else begin
            if (lf_set_i && lf_legal) lf50_q <= lf_want_50;
            lf_bad_q <= lf_set_i && !lf_legal;
            lf_rv_q  <= lf_query_i;
            if (lf_query_i) lf_r_q <= lf50_q ? dms_pkg::LF_50 : dms_pkg::LF_60;
        end
    end
    assign lf_is_50_o      = lf50_q;
    assign lf_bad_value_o  = lf_bad_q;
    assign lf_resp_valid_o = lf_rv_q;
    assign lf_resp_o       = lf_r_q;

    // ==========================================================
    // power-on self-test
    dms_pkg::dms_post_t post_q;
    logic [$clog2(POST_LIMIT+1)-1:0] post_cnt_q;
    logic test_fail_pulse_q;             // one-shot self-test failure

    // wait for link, give up after the limit
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            post_q            <= dms_pkg::DMS_ST_TEST;
            post_cnt_q        <= '0;
            test_fail_pulse_q <= 1'b0;
        end else begin
            test_fail_pulse_q <= 1'b0;
            case (post_q)
                dms_pkg::DMS_ST_TEST: begin
                    if (link_q) begin
                        post_q <= dms_pkg::DMS_ST_OK;
                    end else if (post_cnt_q == ($clog2(POST_LIMIT+1))'(POST_LIMIT - 1)) begin
                        post_q            <= dms_pkg::DMS_ST_FAIL;
                        test_fail_pulse_q <= 1'b1;
                    end else begin
                        post_cnt_q <= post_cnt_q + 1'b1;
                    end
                end
                dms_pkg::DMS_ST_OK:   post_q <= dms_pkg::DMS_ST_OK;
                dms_pkg::DMS_ST_FAIL: post_q <= dms_pkg::DMS_ST_FAIL;
                default:              post_q <= dms_pkg::DMS_ST_TEST;
            endcase
        end
    end

    // ==========================================================
    // error queue; one source per cycle, self-test first; a clear never loses a new error
    wire             push = test_fail_pulse_q || cmd_err_i || cal_err_i;
    wire [ERR_W-1:0] push_code = test_fail_pulse_q ? test_err_code_i :
                                 cmd_err_i ? cmd_err_code_i : cal_err_code_i;
    wire [ERR_W-1:0] head;
    wire             q_empty;

    dms_err_fifo #(
        .WIDTH (ERR_W),
        .DEPTH (ERR_DEPTH)
    ) u_queue (
        .clk_i   (clk_i),
        .reset_i (reset_i),
        .push_i  (push),
        .data_i  (push_code),
        .pop_i   (err_query_i),
        .clear_i (clear_status_i),
        .head_o  (head),
        .empty_o (q_empty),
        .full_o  ()                 // overflow is dropped inside the queue
    );

    // error query answer
    logic             erv_q;
    logic [ERR_W-1:0] er_q;
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            erv_q <= 1'b0;
            er_q  <= ERR_W'(dms_pkg::ERR_NONE);
        end else begin
            erv_q <= err_query_i;
            if (err_query_i) er_q <= q_empty ? ERR_W'(dms_pkg::ERR_NONE) : head;
        end
    end
    assign err_resp_valid_o = erv_q;
    assign err_resp_o       = er_q;

    // ==========================================================
    // front panel lamps and interrupter line
    logic fail_q, acc_q, errl_q, smp_q, irq_q;
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            fail_q <= 1'b1;
            acc_q  <= 1'b0;
            errl_q <= 1'b0;
            smp_q  <= 1'b0;
            irq_q  <= 1'b0;
        end else begin
            fail_q <= (post_q != dms_pkg::DMS_ST_OK);
            acc_q  <= mgr_busy_i;
            errl_q <= !q_empty;
            smp_q  <= samp_q;
            irq_q  <= irq_req_i;
        end
    end
    assign led_failed_o = fail_q;
    assign led_access_o = acc_q;
    assign led_errors_o = errl_q;
    assign led_sample_o = smp_q;
    assign irq_o        = irq_q;
endmodule : dms_setup_status

//--- bench/dms_setup_status_properties.sv
// checker for the setup and status block, bound to every instance
// assumes dms_pkg is compiled first and a single clock domain
module dms_setup_status_props #(
    parameter int ERR_W = 16
) (
    input wire logic             clk_i,
    input wire logic             reset_i,
    input wire logic [7:0]       addr_switch_i,
    input wire logic             lf_set_i,
    input wire logic [8:0]       lf_value_i,
    input wire logic             lf_query_i,
    input wire logic             int_link_ok_i,
    input wire logic             mgr_busy_i,
    input wire logic             cmd_err_i,
    input wire logic             cal_err_i,
    input wire logic             err_query_i,
    input wire logic             clear_status_i,
    input wire logic [7:0]       log_addr_o,
    input wire logic             addr_dynamic_o,
    input wire logic             lf_is_50_o,
    input wire logic             lf_resp_valid_o,
    input wire logic             err_resp_valid_o,
    input wire logic [ERR_W-1:0] err_resp_o,
    input wire logic             led_failed_o,
    input wire logic             led_access_o,
    input wire logic             led_errors_o
);
    timeunit 1ns;
    timeprecision 1ns;
    // ==========================================================
    // properties, rising edge, quiet while reset is high
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);
    chk_lf_answer: assert property (lf_query_i |=> lf_resp_valid_o)
        else $error("line frequency query left unanswered");
    chk_lf_sub_harm: assert property (lf_set_i && lf_value_i == dms_pkg::LF_400 |=> lf_is_50_o)
        else $error("400 Hz setting did not store 50 Hz");
    chk_power_on: assert property ($fell(reset_i) |-> led_failed_o && !lf_is_50_o && !led_errors_o)
        else $error("state after reset is wrong");
    chk_link_lamp: assert property (int_link_ok_i [*8] |-> !led_failed_o)
        else $error("failure lamp lit with internal link up");
    chk_err_answer: assert property (err_query_i |=> err_resp_valid_o)
        else $error("error query left unanswered");
    chk_clear_empty: assert property (clear_status_i && !cmd_err_i && !cal_err_i ##1 err_query_i
        |=> err_resp_o == dms_pkg::ERR_NONE)
        else $error("query after clear returned an entry");
    chk_err_lamp: assert property (cmd_err_i |=> ##[0:2] led_errors_o)
        else $error("error lamp dark after a failed command");
    chk_access_src: assert property (led_access_o |-> $past(mgr_busy_i))
        else $error("access lamp lit without manager traffic");
    chk_static_addr: assert property (addr_switch_i inside {[8'h01:8'hFE]}
        |=> log_addr_o == $past(addr_switch_i)) else $error("static address not taken from switch");
    chk_dyn_wait: assert property (addr_dynamic_o |-> log_addr_o == dms_pkg::ADDR_NONE)
        else $error("address shown while waiting for assignment");
endmodule : dms_setup_status_props
bind dms_setup_status dms_setup_status_props #(.ERR_W(ERR_W)) i_props (.*);

//--- bench/dms_mgr_model.sv
// resource manager stand-in: talks to a block waiting at 255, then assigns
// assumes the waiting flag is a registered level of the block
module dms_mgr_model #(
    parameter logic [7:0] ASSIGN = 8'h20, // unique, multiple of 8
    parameter int         DELAY  = 4      // cycles of traffic before assigning
) (
    input  wire logic       clk_i,
    input  wire logic       reset_i,
    input  wire logic       waiting_i, // block asks for an address
    output logic            busy_o,    // manager talking to the block
    output logic            assign_o,  // one-cycle assignment strobe
    output logic      [7:0] addr_o     // assigned address while strobed
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] cnt_q; // cycles spent on the waiting block
    // ==========================================================
    // count while the block waits, restart when it stops waiting
    always_ff @(posedge clk_i) begin
        if (reset_i || !waiting_i) begin
            cnt_q <= 8'h00;
        end else if (cnt_q != 8'hFF) begin
            cnt_q <= cnt_q + 8'h01;
        end
    end
    assign busy_o   = waiting_i && (cnt_q <= 8'(DELAY));
    assign assign_o = waiting_i && (cnt_q == 8'(DELAY));
    assign addr_o   = assign_o ? ASSIGN : ~ASSIGN; // no stale value off strobe
endmodule : dms_mgr_model

//--- bench/tb_top.sv
// self-checking bench for the setup and status block
// assumes dms_pkg, the checker and the manager model are compiled first
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    // ==========================================================
    // stimulus, observed outputs and bookkeeping
    logic        clk_i, reset_i, lf_set_i, lf_query_i, int_link_ok_i, sampling_i, irq_req_i;
    logic        cmd_err_i, cal_err_i, err_query_i, clear_status_i;
    logic [7:0]  addr_switch_i, log_addr_o;
    logic [8:0]  lf_value_i, lf_resp_o;
    logic [15:0] cmd_err_code_i, cal_err_code_i, test_err_code_i, err_resp_o;
    wire logic   dyn_assign_i, mgr_busy_i;
    wire logic [7:0] dyn_addr_i;
    logic        addr_dynamic_o, lf_is_50_o, lf_resp_valid_o, lf_bad_value_o, err_resp_valid_o;
    logic        led_failed_o, led_access_o, led_errors_o, led_sample_o, irq_o;
    int          errors, cmp_count, cycles;
    dms_setup_status #(.POST_LIMIT(20)) i_dut (.*);
    dms_mgr_model #(.ASSIGN(8'h20), .DELAY(4)) i_mgr (
        .clk_i    (clk_i),
        .reset_i  (reset_i),
        .waiting_i(addr_dynamic_o),
        .busy_o   (mgr_busy_i),
        .assign_o (dyn_assign_i),
        .addr_o   (dyn_addr_i)
    );
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    // hang guard
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 2000) begin
            errors++;
            close_out();
        end
    end
    // ==========================================================
    // helpers: drive just after an edge, compare, report
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask : cyc
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic close_out();
        $display("errors=%0d compares=%0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : close_out
    task automatic do_reset(input logic link);
        reset_i = 1'b1; int_link_ok_i = link; cyc(3); reset_i = 1'b0;
    endtask : do_reset
    task automatic ask_err(input logic [15:0] exp);
        err_query_i = 1'b1; cyc(1); err_query_i = 1'b0;
        chk(16'(err_resp_valid_o), 16'h0001);
        chk(err_resp_o, exp);
        cyc(1);
    endtask : ask_err
    // ==========================================================
    // scenarios
    task automatic t_post();
        chk(16'(led_failed_o), 16'h0001);
        cyc(30);
        chk(16'(led_failed_o), 16'h0001);
        ask_err(test_err_code_i);
        ask_err(dms_pkg::ERR_NONE);
        do_reset(1'b1); cyc(10);
        chk(16'(led_failed_o), 16'h0000);
        chk(16'(lf_is_50_o), 16'h0000);
        chk(16'(log_addr_o), 16'(dms_pkg::ADDR_FACTORY));
    endtask : t_post
    task automatic t_lf();
        logic [8:0] tab [4];
        tab = '{dms_pkg::LF_50, dms_pkg::LF_60, dms_pkg::LF_400, 9'h064};
        for (int i = 0; i < 4; i++) begin
            lf_set_i = 1'b1; lf_value_i = tab[i]; cyc(1); lf_set_i = 1'b0;
            chk(16'(lf_bad_value_o), 16'(i == 3));
            chk(16'(lf_is_50_o), 16'(i != 1));
            lf_query_i = 1'b1; cyc(1); lf_query_i = 1'b0;
            chk(16'(lf_resp_valid_o), 16'h0001);
            chk(16'(lf_resp_o), 16'(i == 1 ? dms_pkg::LF_60 : dms_pkg::LF_50));
            cyc(1);
        end
    endtask : t_lf
    task automatic t_err();
        cmd_err_i = 1'b1; cyc(1); cmd_err_i = 1'b0;
        cal_err_i = 1'b1; cyc(1); cal_err_i = 1'b0; cyc(2);
        chk(16'(led_errors_o), 16'h0001);
        ask_err(cmd_err_code_i);
        ask_err(cal_err_code_i);
        ask_err(dms_pkg::ERR_NONE);
        chk(16'(led_errors_o), 16'h0000);
        cmd_err_i = 1'b1; cyc(1); cmd_err_i = 1'b0;
        clear_status_i = 1'b1; cyc(1); clear_status_i = 1'b0;
        ask_err(dms_pkg::ERR_NONE);
        // an error arriving in the clear cycle is kept
        cmd_err_i = 1'b1;
        clear_status_i = 1'b1;
        cyc(1);
        cmd_err_i = 1'b0;
        clear_status_i = 1'b0;
        ask_err(cmd_err_code_i);
        ask_err(dms_pkg::ERR_NONE);
        // nine errors into eight places: the last is dropped, order kept
        for (int i = 0; i <= 8; i++) begin
            cmd_err_i = 1'b1;
            cmd_err_code_i = 16'(i);
            cyc(1);
        end
        cmd_err_i = 1'b0;
        for (int i = 0; i < 8; i++) begin
            ask_err(16'(i));
        end
        ask_err(dms_pkg::ERR_NONE);
    endtask : t_err
    task automatic t_addr();
        addr_switch_i = dms_pkg::ADDR_STAT_MAX; cyc(2);
        chk(16'(log_addr_o), 16'h00FE);
        addr_switch_i = dms_pkg::ADDR_DYNAMIC; cyc(2);
        chk(16'(addr_dynamic_o), 16'h0001);
        for (int n = 0; n < 8 && led_access_o !== 1'b1; n++) cyc(1);
        chk(16'(led_access_o), 16'h0001);
        cyc(10);
        chk(16'(log_addr_o), 16'h0020);
        chk(16'(led_access_o), 16'h0000);
        sampling_i = 1'b1; cyc(6);
        chk(16'(led_sample_o), 16'h0001);
        sampling_i = 1'b0; irq_req_i = 1'b1; cyc(1);
        chk(16'(irq_o), 16'h0001);
        irq_req_i = 1'b0; cyc(6);
        chk(16'(led_sample_o), 16'h0000);
        chk(16'(irq_o), 16'h0000);
    endtask : t_addr
    // main sequence: failed self-test first, then a healthy power-up
    initial begin
        {lf_set_i, lf_query_i, int_link_ok_i, sampling_i, irq_req_i} = '0;
        {cmd_err_i, cal_err_i, err_query_i, clear_status_i} = '0;
        reset_i = 1'b1; addr_switch_i = dms_pkg::ADDR_FACTORY; lf_value_i = dms_pkg::LF_60;
        cmd_err_code_i = 16'h0101; cal_err_code_i = 16'h0202; test_err_code_i = 16'h0BAD;
        do_reset(1'b0);
        t_post();
        t_lf();
        t_err();
        t_addr();
        close_out();
    end
endmodule : tb_top
